/* core/ptl_pkg.sv */
// package: constants for the pcm trunk line transceiver logic
package ptl_pkg;
    localparam int PTL_DIV = 8;
    localparam int PTL_CNT_W = 3;
    localparam logic [2:0] PTL_CNT_RST = 3'h0;
    localparam logic [2:0] PTL_CNT_SYNC = 3'h1;
    localparam logic [2:0] PTL_CLK_HIGH_FROM = 3'h4;
    localparam logic [2:0] PTL_SAMPLE_AT = 3'h2;
    localparam int PTL_CLK_MHZ = 200;
    localparam int PTL_TX_SETUP_NS = 20;
    localparam int PTL_TX_HOLD_NS = 30;
    localparam int PTL_TX_SETUP_CYC = (PTL_TX_SETUP_NS * PTL_CLK_MHZ + 999) / 1000;
    localparam int PTL_TX_HOLD_CYC = (PTL_TX_HOLD_NS * PTL_CLK_MHZ + 999) / 1000;
    localparam int PTL_BUF_DEPTH = 2;
endpackage

/* core/ptl_transceiver.sv */
// design: pcm trunk line transceiver digital core
//
// Overview of operation
// - recovered clock comes from a divide-by-eight counter on the oversample clock.
// - any rising edge on either line input re-phases the counter.
// - while rx_ready is high, each positive line pulse reissues as a one-bit pulse on matching rx output.
// - falling excursions on line inputs neither re-phase nor make rx pulses.
// - rx outputs are retimed to the recovered clock from the oversample clock.
// - quarter-bit period wander within four bits keeps rx/clock phase.
// - wander over four to eight bits may shift the rx/clock phase.
// - rx outputs change only at recovered clock rise, stable at recovered clock fall.
// - tx data inputs are sampled at the local clock falling edge.
// - a sampled one drives the line output low during the local clock high phase.
`timescale 1ns/1ps
module ptl_transceiver
    import ptl_pkg::*;
#(
    parameter int DEPTH = ptl_pkg::PTL_BUF_DEPTH
) (
    // clock and reset; clk is the oversample clock
    input wire logic clk,
    input wire logic rst,
    // receive line side
    input wire logic line_in_pos,
    input wire logic line_in_neg,
    // receive outputs and rx_ready input
    output logic recovered_clock,
    output logic rx_data_pos,
    output logic rx_data_neg,
    output logic rx_valid,
    input wire logic rx_ready,
    // transmit side
    input wire logic local_tx_clock,
    input wire logic tx_data_pos,
    input wire logic tx_data_neg,
    output logic line_drive_pos_o,
    output logic line_drive_pos_oe,
    output logic line_drive_neg_o,
    output logic line_drive_neg_oe
);
    import ptl_pkg::*;

    // ==========================================================
    // decode helpers
    function automatic logic hi_lo(input logic hi_val, input logic lo_val);
        return hi_val & ~lo_val;
    endfunction

    function automatic logic not_empty(input logic [1:0] count);
        return count != 2'h0;
    endfunction

    function automatic logic [1:0] lane_pair(input logic neg_val, input logic pos_val);
        return {neg_val, pos_val};
    endfunction

    // ==========================================================
    // receive: edge detect, counter, pulse capture
    logic [1:0] line_now;
    logic [1:0] line_d_reg;
    logic [1:0] line_d_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [1:0] hit_reg;
    logic [1:0] hit_next;
    logic [1:0] rise;
    logic rclk_reg;
    logic rclk_next;
    logic push;

    assign line_now = lane_pair(line_in_neg, line_in_pos);

    // per-lane rising edge detect; falling edges give nothing
    for (genvar ln = 0; ln < 2; ln++) begin : g_edge
        assign rise[ln] = hi_lo(line_now[ln], line_d_reg[ln]);
    end

    always_comb begin
        line_d_next = line_now;
        if (rise != 2'h0) begin
            cnt_next = PTL_CNT_SYNC;
        end else begin
            cnt_next = cnt_reg + 3'h1;
        end
        // clock high for counts four to seven
        rclk_next = (cnt_reg >= PTL_CLK_HIGH_FROM);
        push = (cnt_reg == PTL_SAMPLE_AT);
        if (push) begin
            hit_next = rise;
        end else begin
            hit_next = hit_reg | rise;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_d_reg <= 2'h0;
            cnt_reg <= PTL_CNT_RST;
            hit_reg <= 2'h0;
            rclk_reg <= 1'b0;
        end else begin
            line_d_reg <= line_d_next;
            cnt_reg <= cnt_next;
            hit_reg <= hit_next;
            rclk_reg <= rclk_next;
        end
    end

    // ==========================================================
    // two-entry buffer of captured bit pairs
    logic [1:0] buf_mem_reg [DEPTH];
    logic [1:0] buf_mem_next [DEPTH];
    logic [1:0] buf_cnt_reg;
    logic [1:0] buf_cnt_next;
    logic [1:0] out_reg;
    logic [1:0] out_next;
    logic outv_reg;
    logic outv_next;
    logic buf_ready;
    logic pop;
    logic has_word;

    assign has_word = not_empty(buf_cnt_reg);
    assign buf_ready = (buf_cnt_reg != 2'(DEPTH));
    // output word advances only at recovered clock rise
    assign pop = (cnt_reg == PTL_CLK_HIGH_FROM) && (!outv_reg || rx_ready);

    always_comb begin
        buf_mem_next = buf_mem_reg;
        buf_cnt_next = buf_cnt_reg;
        out_next = out_reg;
        outv_next = outv_reg;
        if (pop) begin
            outv_next = has_word;
            out_next = has_word ? buf_mem_reg[0] : 2'h0;
            if (has_word) begin
                buf_mem_next[0] = buf_mem_reg[1];
                buf_cnt_next = buf_cnt_reg - 2'h1;
            end
        end
        // word is the pulses seen since the last push
        if (push && (buf_ready || pop)) begin
            buf_mem_next[buf_cnt_next[0]] = hit_reg;
            buf_cnt_next = buf_cnt_next + 2'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                buf_mem_reg[i] <= 2'h0;
            end
            buf_cnt_reg <= 2'h0;
            out_reg <= 2'h0;
            outv_reg <= 1'b0;
        end else begin
            buf_mem_reg <= buf_mem_next;
            buf_cnt_reg <= buf_cnt_next;
            out_reg <= out_next;
            outv_reg <= outv_next;
        end
    end

    // ==========================================================
    // receive outputs
    assign recovered_clock = rclk_reg;
    assign rx_data_pos = out_reg[0];
    assign rx_data_neg = out_reg[1];
    assign rx_valid = outv_reg;

    // ==========================================================
    // transmit: sample at local clock fall, drive during high
    logic hl_d_reg;
    logic hl_d_next;
    logic [1:0] txs_reg;
    logic [1:0] txs_next;
    logic [1:0] drv_reg;
    logic [1:0] drv_next;
    logic tx_fall;

    assign tx_fall = hi_lo(hl_d_reg, local_tx_clock);

    always_comb begin
        hl_d_next = local_tx_clock;
        txs_next = txs_reg;
        if (tx_fall) begin
            txs_next = lane_pair(tx_data_neg, tx_data_pos);
        end
    end

    // drive pulls low only while the local clock is high
    for (genvar ln = 0; ln < 2; ln++) begin : g_drive
        assign drv_next[ln] = local_tx_clock & txs_next[ln];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hl_d_reg <= 1'b0;
            txs_reg <= 2'h0;
            drv_reg <= 2'h0;
        end else begin
            hl_d_reg <= hl_d_next;
            txs_reg <= txs_next;
            drv_reg <= drv_next;
        end
    end

    // ==========================================================
    // transmit outputs, open drain
    assign line_drive_pos_o = 1'b0;
    assign line_drive_neg_o = 1'b0;
    assign line_drive_pos_oe = drv_reg[0];
    assign line_drive_neg_oe = drv_reg[1];
endmodule

/* tb/ptl_transceiver_asserts.sv */
// checker: transceiver port assertions
`timescale 1ns/1ps
module ptl_transceiver_asserts #(parameter int DEPTH = 2) (
    // clock, reset, rx
    input wire logic clk, rst, line_in_pos, line_in_neg, recovered_clock,
    input wire logic rx_data_pos, rx_data_neg, rx_valid, rx_ready,
    // tx
    input wire logic local_tx_clock, line_drive_pos_o, line_drive_pos_oe,
    input wire logic line_drive_neg_o, line_drive_neg_oe
);
    wire lin = line_in_pos | line_in_neg;
    wire [1:0] rxd = {rx_data_neg, rx_data_pos};
    wire [1:0] oe = {line_drive_neg_oe, line_drive_pos_oe};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_div; ($rose(recovered_clock) && !$rose(lin)) ##1 (!$rose(lin))[*8]
        |-> $rose(recovered_clock); endproperty
    a_div: assert property (p_div) else $error("period");
    property p_low; $fell(recovered_clock) |-> (!recovered_clock)[*3]; endproperty
    a_low: assert property (p_low) else $error("low phase");
    property p_sync; $rose(lin) |-> ##[3:6] $rose(recovered_clock); endproperty
    a_sync: assert property (p_sync) else $error("resync");
    property p_rx; !$stable({rx_valid, rxd}) |-> $rose(recovered_clock); endproperty
    a_rx: assert property (p_rx) else $error("rx timing");
    property p_hold; rx_valid && !rx_ready |=> $stable(rxd); endproperty
    a_hold: assert property (p_hold) else $error("rx hold");
    property p_hi; local_tx_clock[*3] |=> $stable(oe); endproperty
    a_hi: assert property (p_hi) else $error("tx pulse");
    property p_lo; (!local_tx_clock)[*2] |=> oe == 2'h0; endproperty
    a_lo: assert property (p_lo) else $error("tx idle");
    property p_od; !line_drive_pos_o && !line_drive_neg_o; endproperty
    a_od: assert property (p_od) else $error("open drain");
endmodule

bind ptl_transceiver ptl_transceiver_asserts #(.DEPTH(DEPTH)) u_chk (.*);

/* tb/ptl_line_model.sv */
// partner: receive line pulse source
`timescale 1ns/1ps
module ptl_line_model (
    // request
    input wire logic clk,
    input wire logic [1:0] send,
    // line
    output logic line_in_pos,
    output logic line_in_neg
);
    initial {line_in_neg, line_in_pos} = 2'h0;
    // one-cycle positive halves, idle low
    always @(negedge clk) {line_in_neg, line_in_pos} <= send;
endmodule

/* tb/ptl_transceiver_tb.sv */
// bench: transceiver testbench
`timescale 1ns/1ps
module ptl_transceiver_tb;
    logic clk, rst, rx_ready, local_tx_clock, tx_data_pos, tx_data_neg, line_in_pos;
    logic line_in_neg, recovered_clock, rx_data_pos, rx_data_neg, rx_valid, line_drive_pos_o;
    logic line_drive_pos_oe, line_drive_neg_o, line_drive_neg_oe;
    logic [1:0] send;
    int fails = 0, check_count = 0, cyc = 0;
    ptl_line_model line_model (
        .clk(clk),
        .send(send),
        .line_in_pos(line_in_pos),
        .line_in_neg(line_in_neg)
    );
    ptl_transceiver DUT (
        .clk(clk),
        .rst(rst),
        .line_in_pos(line_in_pos),
        .line_in_neg(line_in_neg),
        .recovered_clock(recovered_clock),
        .rx_data_pos(rx_data_pos),
        .rx_data_neg(rx_data_neg),
        .rx_valid(rx_valid),
        .rx_ready(rx_ready),
        .local_tx_clock(local_tx_clock),
        .tx_data_pos(tx_data_pos),
        .tx_data_neg(tx_data_neg),
        .line_drive_pos_o(line_drive_pos_o),
        .line_drive_pos_oe(line_drive_pos_oe),
        .line_drive_neg_o(line_drive_neg_o),
        .line_drive_neg_oe(line_drive_neg_oe)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input logic [2:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rx_is(input logic [2:0] e);
        logic p;
        p = recovered_clock;
        for (int i = 0; i < 20 && !(recovered_clock === 1'b1 && p !== 1'b1); i++) begin
            p = recovered_clock;
            @(negedge clk);
        end
        chk({rx_valid, rx_data_neg, rx_data_pos}, e);
    endtask
    task automatic put(input logic [1:0] v, input logic [2:0] e);
        rx_is(e);
        send <= v;
        @(negedge clk) send <= 2'h0;
    endtask
    task automatic t_rx;
        logic [1:0] pat [5] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h3};
        foreach (pat[i]) begin
            put(pat[i], 3'h4);
            rx_is({1'b1, pat[i]});
        end
        $display("rx done");
    endtask
    task automatic t_stall;
        rx_ready <= 1'b0;
        for (int i = 1; i < 4; i++) put(i[1:0], 3'h7);
        rx_is(3'h7);
        rx_ready <= 1'b1;
        rx_is(3'h4);
        rx_is(3'h5);
        rst <= 1'b1;
        rx_is(3'h0);
        rst <= 1'b0;
        rx_is(3'h4);
        $display("stall done");
    endtask
    task automatic t_tx;
        for (int d = 0; d < 4; d++) begin
            {tx_data_neg, tx_data_pos} <= d[1:0];
            repeat (6) @(negedge clk);
            local_tx_clock <= 1'b0;
            repeat (7) @(negedge clk);
            chk({1'b0, line_drive_neg_oe, line_drive_pos_oe}, 3'h0);
            {tx_data_neg, tx_data_pos} <= ~d[1:0];
            @(negedge clk) local_tx_clock <= 1'b1;
            repeat (5) @(negedge clk);
            chk({1'b0, line_drive_neg_oe, line_drive_pos_oe}, {1'b0, d[1:0]});
        end
        $display("tx done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {rst, rx_ready, local_tx_clock, tx_data_neg, tx_data_pos, send} = 7'h70;
        repeat (12) @(negedge clk);
        rst <= 1'b0;
        t_rx();
        t_stall();
        t_tx();
        close_out();
    end
endmodule
